// ---- core/apc_clock_gen.sv ----
// apc_clock_gen.sv: bit and frame clock generator for two audio serial ports,
// apb register slave included.
// assumes domain clock ticks arrive as pclk-synchronous pulses, one per domain
// clock cycle, and that software respects the rate ceiling of each domain.
`timescale 1ns/1ps
`default_nettype none
`include "apc_defines.svh"

module apc_clock_gen
  import apc_pkg::*;
#(
  parameter logic [31:0] SYS_CLK_HZ   = `APC_SYS_CLK_HZ,
  parameter logic [31:0] ASYNC_CLK_HZ = `APC_ASYNC_CLK_HZ
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        system_domain_tick,
  input  wire logic        async_domain_tick,
  output var  logic [1:0]  port_bit_clock_drv,
  output var  logic [1:0]  port_bit_clock_oe,
  input  wire logic [1:0]  port_bit_clock_rx,
  output var  logic [1:0]  port_frame_clock_drv,
  output var  logic [1:0]  port_frame_clock_oe,
  input  wire logic [1:0]  port_frame_clock_rx
);

  //////////////////////////////////////////////////////////////////////////////
  // rate table

  // bit clock frequency in hertz for a code and family; reserved codes give 0
  function automatic logic [31:0] rate_hz(input logic [4:0] code, input logic fam441);
    logic [31:0] f48;
    logic [31:0] f44;
    f48 = 32'h0;
    f44 = 32'h0;
    unique case (code)
      5'h02: begin f48 = 32'd64000;    f44 = 32'd58800;    end
      5'h03: begin f48 = 32'd96000;    f44 = 32'd88200;    end
      5'h04: begin f48 = 32'd128000;   f44 = 32'd117600;   end
      5'h05: begin f48 = 32'd192000;   f44 = 32'd176400;   end
      5'h06: begin f48 = 32'd256000;   f44 = 32'd235200;   end
      5'h07: begin f48 = 32'd384000;   f44 = 32'd352800;   end
      5'h08: begin f48 = 32'd512000;   f44 = 32'd470400;   end
      5'h09: begin f48 = 32'd768000;   f44 = 32'd705600;   end
      5'h0a: begin f48 = 32'd1024000;  f44 = 32'd940800;   end
      5'h0b: begin f48 = 32'd1536000;  f44 = 32'd1411200;  end
      5'h0c: begin f48 = 32'd2048000;  f44 = 32'd1881600;  end
      5'h0d: begin f48 = 32'd3072000;  f44 = 32'd2822400;  end
      5'h0e: begin f48 = 32'd4096000;  f44 = 32'd3763200;  end
      5'h0f: begin f48 = 32'd6144000;  f44 = 32'd5644800;  end
      5'h10: begin f48 = 32'd8192000;  f44 = 32'd7526400;  end
      5'h11: begin f48 = 32'd12288000; f44 = 32'd11289600; end
      default: begin f48 = 32'h0; f44 = 32'h0; end  // reserved or above the table
    endcase
    return fam441 ? f44 : f48;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // apb slave: no wait state; read data is registered in the setup cycle and comes from a flip-flop

  apc_port_cfg_s cfg_reg [2];
  logic [4:0]    sample_rate_reg;
  logic [4:0]    async_sample_rate_reg;
  logic [1:0]    domain_async;
  logic [1:0]    family_441;
  logic [1:0]    running;
  logic [11:0]   rd_idx;
  logic          addr_ok;
  logic          wr_fire;
  logic [31:0]   rd_word;
  logic [4:0]    status_word [2];

  assign rd_idx  = paddr[13:2];
  assign wr_fire = psel && penable && pready && pwrite;

  // address decode and read mux; unmapped or misaligned words answer with an error
  always_comb begin
    addr_ok = (paddr[1:0] == 2'h0) && (paddr[15:14] == 2'h0);
    rd_word = 32'h0;
    unique case (rd_idx)
      `APC_IDX_P1_BCLK_CTRL: rd_word = {27'h0, cfg_reg[0].bit_clock_rate_code};
      `APC_IDX_P1_FRAME_LEN: rd_word = {19'h0, cfg_reg[0].frame_length_divider};
      `APC_IDX_P1_PORT_CFG:  rd_word = {27'h0, cfg_reg[0].frame_clock_master_select,
                                        cfg_reg[0].port_rate_setting};
      `APC_IDX_P1_CHAN_EN:   rd_word = {20'h0, cfg_reg[0].chan_en};
      `APC_IDX_P1_STATUS:    rd_word = {27'h0, status_word[0]};
      `APC_IDX_P2_BCLK_CTRL: rd_word = {27'h0, cfg_reg[1].bit_clock_rate_code};
      `APC_IDX_P2_FRAME_LEN: rd_word = {19'h0, cfg_reg[1].frame_length_divider};
      `APC_IDX_P2_PORT_CFG:  rd_word = {27'h0, cfg_reg[1].frame_clock_master_select,
                                        cfg_reg[1].port_rate_setting};
      `APC_IDX_P2_CHAN_EN:   rd_word = {20'h0, cfg_reg[1].chan_en};
      `APC_IDX_P2_STATUS:    rd_word = {27'h0, status_word[1]};
      `APC_IDX_SAMPLE_RATES: rd_word = {19'h0, async_sample_rate_reg, 3'h0, sample_rate_reg};
      default:               addr_ok = 1'b0;
    endcase
  end

  // pready rises in the first access cycle and drops right after
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata  <= (psel && !penable && !pwrite && addr_ok) ? rd_word : 32'h0;
    end
  end

  // shared sample rate settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_rate_reg       <= 5'h0;
      async_sample_rate_reg <= 5'h0;
    end else if (wr_fire && addr_ok && rd_idx == `APC_IDX_SAMPLE_RATES) begin
      sample_rate_reg       <= pwdata[4:0];
      async_sample_rate_reg <= pwdata[`APC_SR_ASYNC_LSB +: 5];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-port configuration and clock generation

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      localparam logic [11:0] IDX_CTRL = (p == 0) ? `APC_IDX_P1_BCLK_CTRL : `APC_IDX_P2_BCLK_CTRL;
      localparam logic [11:0] IDX_FLEN = (p == 0) ? `APC_IDX_P1_FRAME_LEN : `APC_IDX_P2_FRAME_LEN;
      localparam logic [11:0] IDX_CFG  = (p == 0) ? `APC_IDX_P1_PORT_CFG  : `APC_IDX_P2_PORT_CFG;
      localparam logic [11:0] IDX_CHEN = (p == 0) ? `APC_IDX_P1_CHAN_EN   : `APC_IDX_P2_CHAN_EN;

      logic        locked;
      logic        tick;
      logic [31:0] dom_hz;
      logic [31:0] step;
      logic [32:0] acc_sum;
      logic [31:0] acc_reg;
      logic        bclk_reg;
      logic        frame_reg;
      logic [12:0] bit_cnt_reg;
      logic        half_edge;
      logic        bclk_fall;
      logic [12:0] wrap_at;

      assign locked = |cfg_reg[p].chan_en;

      // configuration writes; rate code and master select freeze while channels run
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cfg_reg[p].bit_clock_rate_code       <= `APC_RST_RATE_CODE;
          cfg_reg[p].frame_length_divider      <= `APC_RST_FRAME_LEN;
          cfg_reg[p].port_rate_setting         <= 4'h0;
          cfg_reg[p].frame_clock_master_select <= 1'b0;
          cfg_reg[p].chan_en                   <= 12'h0;
        end else if (wr_fire && addr_ok) begin
          if (rd_idx == IDX_CTRL && !locked) begin
            cfg_reg[p].bit_clock_rate_code <= pwdata[4:0];
          end
          if (rd_idx == IDX_FLEN) begin
            cfg_reg[p].frame_length_divider <= pwdata[12:0];
          end
          if (rd_idx == IDX_CFG) begin
            cfg_reg[p].port_rate_setting <= pwdata[3:0];
            if (!locked) begin
              cfg_reg[p].frame_clock_master_select <= pwdata[`APC_CFG_MASTER_BIT];
            end
          end
          if (rd_idx == IDX_CHEN) begin
            cfg_reg[p].chan_en <= pwdata[11:0];
          end
        end
      end

      // domain and family choice
      always_comb begin
        domain_async[p] = cfg_reg[p].port_rate_setting >= `APC_ASYNC_RATE_MIN;
        if (domain_async[p]) begin
          family_441[p] = async_sample_rate_reg[4:3] == `APC_FAMILY_441;
        end else begin
          family_441[p] = sample_rate_reg[4:3] == `APC_FAMILY_441;
        end
        tick    = domain_async[p] ? async_domain_tick : system_domain_tick;
        dom_hz  = domain_async[p] ? ASYNC_CLK_HZ : SYS_CLK_HZ;
        step    = rate_hz(cfg_reg[p].bit_clock_rate_code, family_441[p]);
        running[p] = cfg_reg[p].frame_clock_master_select && locked && (step != 32'h0);
      end

      // fractional divider: two half periods per bit clock, each worth dom_hz / (2 f)
      // domain ticks; relies on f at most half the domain rate so one tick toggles at most once
      // the remainder stays in acc_reg, so uneven ratios average out exactly and no half
      // period is ever more than one tick away from its ideal length
      assign acc_sum   = {1'b0, acc_reg} + {1'b0, step[30:0], 1'b0};
      assign half_edge = running[p] && tick && (acc_sum >= {1'b0, dom_hz});
      assign bclk_fall = half_edge && bclk_reg;
      assign wrap_at   = (cfg_reg[p].frame_length_divider == 13'h0)
                         ? 13'h0 : cfg_reg[p].frame_length_divider - 13'h1;

      // phase accumulator on domain ticks
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          acc_reg <= 32'h0;
        end else if (!running[p]) begin
          acc_reg <= 32'h0;
        end else if (tick) begin
          if (half_edge) begin
            acc_reg <= 32'(acc_sum - {1'b0, dom_hz});
          end else begin
            acc_reg <= acc_sum[31:0];  // below dom_hz here, so the top bit is zero
          end
        end
      end

      // bit clock output, master only
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          bclk_reg <= 1'b0;
        end else if (!running[p]) begin
          bclk_reg <= 1'b0;
        end else if (half_edge) begin
          bclk_reg <= !bclk_reg;
        end
      end

      // frame clock: high for the first half of each frame of bit clocks
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          bit_cnt_reg <= 13'h0;
          frame_reg   <= 1'b0;
        end else if (!running[p]) begin
          bit_cnt_reg <= 13'h0;
          frame_reg   <= 1'b0;
        end else if (bclk_fall) begin
          if (bit_cnt_reg >= wrap_at) begin
            bit_cnt_reg <= 13'h0;
            frame_reg   <= 1'b1;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 13'h1;
            frame_reg   <= (bit_cnt_reg + 13'h1) < {1'b0, cfg_reg[p].frame_length_divider[12:1]};
          end
        end
      end

      // pin outputs; enables follow the master select so slave pins stay undriven
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          port_bit_clock_drv[p]   <= 1'b0;
          port_bit_clock_oe[p]    <= 1'b0;
          port_frame_clock_drv[p] <= 1'b0;
          port_frame_clock_oe[p]  <= 1'b0;
        end else begin
          port_bit_clock_drv[p]   <= bclk_reg;
          port_bit_clock_oe[p]    <= cfg_reg[p].frame_clock_master_select;
          port_frame_clock_drv[p] <= frame_reg;
          port_frame_clock_oe[p]  <= cfg_reg[p].frame_clock_master_select;
        end
      end

      // status: domain, family, running and the sampled pin levels
      always_comb begin
        status_word[p] = 5'h0;
        status_word[p][`APC_ST_DOMAIN_BIT]   = domain_async[p];
        status_word[p][`APC_ST_FAMILY_BIT]   = family_441[p];
        status_word[p][`APC_ST_RUNNING_BIT]  = running[p];
        status_word[p][`APC_ST_BCLK_RX_BIT]  = port_bit_clock_rx[p];
        status_word[p][`APC_ST_FRAME_RX_BIT] = port_frame_clock_rx[p];
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ---- core/apc_defines.svh ----
// apc_defines.svh: register indices, field positions, reset values and
// timing figures of the audio port bit/frame clock generator.
// assumes apb with 32-bit data; a register index times four is its byte address.
`ifndef APC_DEFINES_SVH
`define APC_DEFINES_SVH

// register indices (byte address = index * 4)
`define APC_IDX_P1_BCLK_CTRL   12'h500
`define APC_IDX_P1_FRAME_LEN   12'h506
`define APC_IDX_P1_PORT_CFG    12'h501
`define APC_IDX_P1_CHAN_EN     12'h502
`define APC_IDX_P1_STATUS      12'h503
`define APC_IDX_P2_BCLK_CTRL   12'h540
`define APC_IDX_P2_FRAME_LEN   12'h546
`define APC_IDX_P2_PORT_CFG    12'h541
`define APC_IDX_P2_CHAN_EN     12'h542
`define APC_IDX_P2_STATUS      12'h543
`define APC_IDX_SAMPLE_RATES   12'h600

// reset values
`define APC_RST_RATE_CODE      5'h0c
`define APC_RST_FRAME_LEN      13'h0040

// field positions
`define APC_CFG_MASTER_BIT     4
`define APC_SR_ASYNC_LSB       8
`define APC_ST_DOMAIN_BIT      0
`define APC_ST_FAMILY_BIT      1
`define APC_ST_RUNNING_BIT     2
`define APC_ST_BCLK_RX_BIT     3
`define APC_ST_FRAME_RX_BIT    4

// domain threshold and family pattern
`define APC_ASYNC_RATE_MIN     4'h8
`define APC_FAMILY_441         2'h1

// default domain clock rates in hertz
`define APC_SYS_CLK_HZ         32'd49152000
`define APC_ASYNC_CLK_HZ       32'd45158400

`endif

// ---- core/apc_pkg.sv ----
// apc_pkg.sv: types shared by the audio port clock generator.
// assumes apc_defines.svh is compiled alongside.
package apc_pkg;

  // per-port software configuration
  typedef struct packed {
    logic [4:0]  bit_clock_rate_code;
    logic [12:0] frame_length_divider;
    logic [3:0]  port_rate_setting;
    logic        frame_clock_master_select;
    logic [11:0] chan_en;
  } apc_port_cfg_s;

  // two-way clock pin seen by the core
  typedef struct packed {
    logic drv;
    logic oe;
  } apc_pin_s;

endpackage

// ---- test/apc_clock_gen_properties.sv ----
// apc_clock_gen_properties.sv: port-level checks of the clock generator.
// assumes it is bound to apc_clock_gen and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module apc_clock_gen_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  port_bit_clock_drv,
  input wire logic [1:0]  port_bit_clock_oe,
  input wire logic [1:0]  port_frame_clock_drv,
  input wire logic [1:0]  port_frame_clock_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  // register bus: one access cycle, answer only with ready
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  ////////////////////////////////////////////////////////////////////////////
  // pins: both enables follow master select, slave ports stay quiet
  a_oe_pair_same: assert property (port_bit_clock_oe == port_frame_clock_oe)
    else $error("pin enables differ");
  a_slave_quiet_one: assert property ((!port_bit_clock_oe[0])[*3] |->
    !port_bit_clock_drv[0] && !port_frame_clock_drv[0])
    else $error("port one drives in slave mode");
  a_slave_quiet_two: assert property ((!port_bit_clock_oe[1])[*3] |->
    !port_bit_clock_drv[1] && !port_frame_clock_drv[1])
    else $error("port two drives in slave mode");
  a_bclk_needs_oe: assert property ($rose(port_bit_clock_drv[1]) |-> port_bit_clock_oe[1])
    else $error("bit clock runs without master");
  // frame wrap happens on a bit clock falling edge
  a_frame_on_fall: assert property ($rose(port_frame_clock_drv[0])
    |-> $fell(port_bit_clock_drv[0]))
    else $error("frame clock rose off bit clock fall");
endmodule
bind apc_clock_gen apc_clock_gen_properties i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .port_bit_clock_drv(port_bit_clock_drv),
  .port_bit_clock_oe(port_bit_clock_oe), .port_frame_clock_drv(port_frame_clock_drv),
  .port_frame_clock_oe(port_frame_clock_oe));
`default_nettype wire

// ---- test/apc_far_end.sv ----
// apc_far_end.sv: far audio processor, clock master toward slave ports.
// assumes pclk timing; its clocks stand still while run is low.
`timescale 1ns/1ps
`default_nettype none
module apc_far_end (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic [1:0] bit_oe,
  input  wire logic [1:0] bit_drv,
  input  wire logic [1:0] frame_oe,
  input  wire logic [1:0] frame_drv,
  output var  logic [1:0] bit_rx,
  output var  logic [1:0] frame_rx
);
  logic [8:0] cnt_reg;
  // own clocks: bit clock of 8 pclk, frame of 64 bit clocks, no divider needed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_reg <= 9'h000;
    else if (run) cnt_reg <= cnt_reg + 9'h001;
  end
  // wire level: whoever has the enable drives the pin
  assign bit_rx   = (bit_oe & bit_drv) | (~bit_oe & {2{cnt_reg[2]}});
  assign frame_rx = (frame_oe & frame_drv) | (~frame_oe & {2{cnt_reg[8]}});
endmodule
`default_nettype wire

// ---- test/tb_apc_clock_gen.sv ----
// tb_apc_clock_gen.sv: self-checking bench of the clock generator.
// assumes system ticks every pclk and async ticks every second pclk.
`timescale 1ns/1ps
`default_nettype none
`include "apc_defines.svh"
module tb_apc_clock_gen;
  localparam logic [31:0] SYS = 32'd3072000;
  localparam logic [31:0] ASY = 32'd2822400;
  localparam int F48 [8] = '{64000, 96000, 128000, 192000, 256000, 384000, 512000, 768000};
  localparam int F44 [8] = '{58800, 88200, 117600, 176400, 235200, 352800, 470400, 705600};
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} apc_note_s;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0;
  logic        tick_a = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, ce;
  logic        pready, pslverr;
  logic [1:0]  bdrv, boe, brx, fdrv, foe, frx;
  logic [2:0]  r3;
  int          failures = 0, cmp_count = 0, cyc = 0, n, dv;
  apc_note_s   q[$];
  apc_note_s   nt;
  initial forever #5 pclk = ~pclk;
  // slower async ticks make a port timed from the wrong domain show a wrong period
  always @(posedge pclk) tick_a <= ~tick_a;
  apc_clock_gen #(.SYS_CLK_HZ(SYS), .ASYNC_CLK_HZ(ASY)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .system_domain_tick(1'b1), .async_domain_tick(tick_a),
    .port_bit_clock_drv(bdrv), .port_bit_clock_oe(boe), .port_bit_clock_rx(brx),
    .port_frame_clock_drv(fdrv), .port_frame_clock_oe(foe), .port_frame_clock_rx(frx));
  apc_far_end i_far (.pclk(pclk), .presetn(presetn), .run(run), .bit_oe(boe),
    .bit_drv(bdrv), .frame_oe(foe), .frame_drv(fdrv), .bit_rx(brx), .frame_rx(frx));
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (failures == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // port two registers sit 0x40 above those of port one
  function automatic logic [11:0] pi(input int p, input logic [11:0] i);
    return p ? i + 12'h040 : i;
  endfunction
  // apb transfer; the note holds masked read data and the error flag
  task automatic xfer(input logic w, input logic [11:0] i, input logic [31:0] d,
                      input logic [31:0] m, input logic e);
    q.push_back('{w ? 32'h0 : d, w ? 32'h0 : m, e});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= w ? d : 32'h0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic sg(input int p, input bit fr);
    return fr ? fdrv[p] : bdrv[p];
  endfunction
  task automatic rise(input int p, input bit fr);
    do @(posedge pclk); while (sg(p, fr) !== 1'b0);
    do @(posedge pclk); while (sg(p, fr) !== 1'b1);
  endtask
  // skip a settling period, then count pclk cycles of one whole period
  task automatic period(input int p, input bit fr, output int n);
    int t;
    rise(p, fr);
    rise(p, fr);
    t = cyc;
    rise(p, fr);
    n = cyc - t;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // result watcher and hang limit, far above the few thousand cycles needed
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end else if (psel && penable && pready === 1'b1) begin
      nt = q.pop_front();
      check("prdata", prdata & nt.m, nt.d);
      check("pslverr", pslverr, nt.e);
    end
  end
  initial begin
    void'($urandom(83));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      xfer(0, pi(p, `APC_IDX_P1_BCLK_CTRL), `APC_RST_RATE_CODE, 32'hffffffff, 0);
      xfer(0, pi(p, `APC_IDX_P1_FRAME_LEN), `APC_RST_FRAME_LEN, 32'hffffffff, 0);
    end
    xfer(0, 12'h7ff, 32'h0, 32'hffffffff, 1);
    r3 = 3'($urandom);
    ce = ($urandom % 32'hfff) + 32'h1;
    xfer(1, `APC_IDX_SAMPLE_RATES, {19'h0, 2'b01, r3, 3'h0, 2'b00, r3}, 0, 0);
    xfer(1, `APC_IDX_P1_PORT_CFG, {27'h0, 2'b10, r3}, 0, 0);
    xfer(1, `APC_IDX_P2_PORT_CFG, {27'h0, 2'b11, r3}, 0, 0);
    // valid codes 2 to 9, all below the domain ceiling, on both ports
    for (int c = 0; c < 8; c++) begin
      for (int p = 0; p < 2; p++) begin
        xfer(1, pi(p, `APC_IDX_P1_CHAN_EN), 32'h0, 0, 0);
        xfer(1, pi(p, `APC_IDX_P1_BCLK_CTRL), c + 2, 0, 0);
        xfer(1, pi(p, `APC_IDX_P1_CHAN_EN), ce, 0, 0);
        period(p, 0, n);
        check("bclk period", n, p ? 2 * (ASY / F44[c]) : SYS / F48[c]);
      end
    end
    xfer(0, `APC_IDX_P1_STATUS, 32'h4, 32'h7, 0);
    xfer(0, `APC_IDX_P2_STATUS, 32'h7, 32'h7, 0);
    // locked fields while channels run; the other port stays free
    xfer(1, `APC_IDX_P1_BCLK_CTRL, 32'h3, 0, 0);
    xfer(0, `APC_IDX_P1_BCLK_CTRL, 32'h9, 32'hffffffff, 0);
    xfer(1, `APC_IDX_P1_PORT_CFG, {29'h0, r3}, 0, 0);
    xfer(0, `APC_IDX_P1_PORT_CFG, 32'h10, 32'h10, 0);
    xfer(1, `APC_IDX_P2_CHAN_EN, 32'h0, 0, 0);
    xfer(1, `APC_IDX_P2_BCLK_CTRL, 32'h4, 0, 0);
    xfer(0, `APC_IDX_P2_BCLK_CTRL, 32'h4, 32'hffffffff, 0);
    // frame length is not locked: change it on the fly
    dv = 2 * (($urandom % 7) + 2);
    xfer(1, `APC_IDX_P1_FRAME_LEN, dv, 0, 0);
    period(0, 1, n);
    check("frame period", n, dv * (SYS / F48[7]));
    xfer(1, `APC_IDX_SAMPLE_RATES, {19'h0, 2'b01, r3, 3'h0, 2'b01, r3}, 0, 0);
    xfer(0, `APC_IDX_P1_STATUS, 32'h6, 32'h7, 0);
    // slave mode: pins released, far clock idle at 0 then running
    xfer(1, `APC_IDX_P1_CHAN_EN, 32'h0, 0, 0);
    xfer(1, `APC_IDX_P1_PORT_CFG, {29'h0, r3}, 0, 0);
    xfer(1, `APC_IDX_P1_CHAN_EN, ce, 0, 0);
    xfer(0, `APC_IDX_P1_STATUS, 32'h0, 32'h18, 0);
    check("oe", {28'h0, foe, boe}, 32'ha);
    // far clocks reach the status bits; freeze them so the read sees one level
    run <= 1'b1;
    repeat (300) @(posedge pclk);
    run <= 1'b0;
    repeat (2) @(posedge pclk);
    xfer(0, `APC_IDX_P1_STATUS, {27'h0, frx[0], brx[0], 3'h0}, 32'h18, 0);
    run <= 1'b1;
    repeat (600) @(posedge pclk);
    check("frame drv", {31'h0, fdrv[0]}, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
